// *** display_ram_mem.sv ***
module display_ram_mem #(
    parameter int DEPTH = 35,
    parameter int AW = 6,
    parameter int DW = 4
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];
    wire wr_hit = wr_en && (int'(wr_addr) < DEPTH);
    wire rd_hit = int'(rd_addr) < DEPTH;

    always_ff @(posedge clk) begin
        if (wr_hit) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= rd_hit ? mem[rd_addr] : '0;
    end
endmodule // display_ram_mem

// *** lcd_cmd_pkg.sv ***
package lcd_cmd_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int RAM_DEPTH = 35;
    localparam int ADDR_W = 6;
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam logic [5:0] LAST_ADDR = 6'h22;
    localparam logic [5:0] FIRST_ADDR = 6'h00;

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    localparam logic [3:0] CNT_IDLE = 4'h0;
    localparam logic [3:0] CNT_NIBBLE = 4'h4;
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam int BIT_CFLAG = 7;

    // ----------------------------------------
    // Command prefixes, taken from bit 6 down
    // ----------------------------------------
    localparam logic [4:0] PFX_ALL_PIXEL = 5'h1f;
    localparam logic [3:0] PFX_BLINK = 4'he;
    localparam logic [3:0] PFX_IC_OP = 4'hd;
    localparam logic [1:0] PFX_MODE = 2'h2;
    localparam logic [1:0] PFX_DISPLAY = 2'h1;
    localparam logic [1:0] PFX_ADDRESS = 2'h0;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_DISP_ON = 3;
    localparam int BIT_BIAS = 2;
    localparam int FR_HI = 4;
    localparam int FR_LO = 3;
    localparam int BIT_INVERT = 2;
    localparam int DRV_HI = 1;
    localparam int DRV_LO = 0;
    localparam int BIT_ADDR_MSB = 2;
    localparam int BIT_SOFT_RST = 1;
    localparam int BIT_EXT_CLK = 0;
    localparam int BLK_HI = 1;
    localparam int BLK_LO = 0;
    localparam int BIT_ALL_ON = 1;
    localparam int BIT_ALL_OFF = 0;
    localparam int ADDR_LO_HI = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RST_DISP_ON = 1'b0;
    localparam logic RST_BIAS = 1'b0;
    localparam logic [1:0] RST_FRAME = 2'b00;
    localparam logic RST_INVERT = 1'b0;
    localparam logic [1:0] RST_DRIVE = 2'b10;
    localparam logic RST_ADDR_MSB = 1'b0;
    localparam logic RST_EXT_CLK = 1'b0;
    localparam logic [1:0] RST_BLINK = 2'b00;
    localparam logic RST_ALL_ON = 1'b0;
    localparam logic RST_ALL_OFF = 1'b0;

    function automatic logic [5:0] next_addr(input logic [5:0] a);
        next_addr = (a == LAST_ADDR) ? FIRST_ADDR : 6'(a + 6'h01);
    endfunction

endpackage

// *** lcd_host_model.sv ***
module lcd_host_model (
    output logic sclk,
    output logic csn,
    output logic sd
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Link clock, free of the core clock phase
    // ----------------------------------------
    logic link_clk;

    initial begin
        link_clk = 1'b0;
        sclk = 1'b0;
        csn = 1'b1;
        sd = 1'b0;
        #13;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic begin_frame();
        @(posedge link_clk);
        csn <= 1'b0;
        @(posedge link_clk);
    endtask

    // Released line shows the inverse
    task automatic end_frame();
        @(posedge link_clk);
        csn <= 1'b1;
        sd <= ~sd;
        repeat (2) @(posedge link_clk);
    endtask

    // MSB first, bytes back to back
    task automatic put_bits(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge link_clk);
            sclk <= 1'b0;
            sd <= v[i];
            repeat (2) @(posedge link_clk);
            sclk <= 1'b1;
            @(posedge link_clk);
        end
        @(posedge link_clk);
        sclk <= 1'b0;
    endtask

    task automatic recover(input logic [7:0] ic_operation_cmd);
        end_frame();
        begin_frame();
        put_bits(ic_operation_cmd, 8);
        end_frame();
    endtask
endmodule // lcd_host_model

// *** lcd_segment_serial_command_decoder.sv ***
// Function
// RULE_01 - Chip select high clears the bit counter; input taken when low.
// RULE_02 - Bytes arrive MSB first, sampled rising, formed at eighth fall.
// RULE_03 - Bit 7 set means next byte is command, clear means data.
// RULE_04 - Mode set loads display on/off and bias choice.
// RULE_05 - Address set loads address bits 4:0; bit 5 from stored MSB.
// RULE_06 - Display control sets frame rate and inversion type.
// RULE_07 - Display control sets drive mode, normal after reset.
// RULE_08 - IC operation stores address MSB, reset zero.
// RULE_09 - IC operation bit 1 set performs software reset.
// RULE_10 - IC operation bit 0 selects internal or external display clock.
// RULE_11 - Blink control sets blink rate, off after reset.
// RULE_12 - All pixel command forces all on or all off.
// RULE_13 - Inhibit input low blanks the display.
// RULE_14 - Display RAM holds 35 words of 4 bits.
// RULE_15 - Data bytes store as two nibbles, address stepping per nibble.
// RULE_16 - Data bytes may follow each other without new commands.
// RULE_17 - Address wraps from 34 back to 0.
// RULE_18 - Partial nibble at chip select rise is dropped.
// RULE_19 - Software reset blanks display and clears address, keeps RAM.
// RULE_20 - Host toggles chip select then issues software reset.
// RULE_21 - Upper nibble first; nibble bit 0 is common line 0.
// RULE_22 - Command prefixes decoded in fixed priority order.
module lcd_segment_serial_command_decoder (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic SERIAL_CLOCK,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_DATA_IN,
    input wire logic DISPLAY_INHIBIT_N,
    input wire logic [5:0] RAM_READ_ADDR,
    output logic [3:0] RAM_READ_DATA,
    output logic [5:0] WRITE_ADDR,
    output logic DISPLAY_ENABLE,
    output logic BIAS_HALF,
    output logic [1:0] FRAME_RATE,
    output logic FRAME_INVERSION,
    output logic [1:0] DRIVE_MODE,
    output logic EXT_CLOCK_SELECT,
    output logic [1:0] BLINK_RATE,
    output logic ALL_PIXELS_ON,
    output logic ALL_PIXELS_OFF
);
    serial_event_if ev ();

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    serial_link_rx u_rx (
        .serial_clock(SERIAL_CLOCK),
        .chip_select_n(CHIP_SELECT_N),
        .serial_data_in(SERIAL_DATA_IN),
        .link_reset(RESET),
        .ev(ev.link)
    );

    // ----------------------------------------
    // Crossing into core clock
    // ----------------------------------------
    logic tg_s1_q;
    logic tg_s2_q;
    logic tg_s3_q;
    logic tg_lvl_q;
    logic inh_s1_q;
    logic inh_s2_q;
    logic inh_s3_q;
    logic inh_q;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
        end else begin
            tg_s1_q <= ev.toggle;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            tg_lvl_q <= 1'b0;
        end else if (tg_s2_q == tg_s3_q) begin
            tg_lvl_q <= tg_s3_q;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            inh_s1_q <= 1'b0;
            inh_s2_q <= 1'b0;
            inh_s3_q <= 1'b0;
        end else begin
            inh_s1_q <= DISPLAY_INHIBIT_N;
            inh_s2_q <= inh_s1_q;
            inh_s3_q <= inh_s2_q;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            inh_q <= 1'b0;
        end else if (inh_s2_q == inh_s3_q) begin
            inh_q <= inh_s3_q;
        end
    end

    // Payload is stable long before the toggle settles
    wire evt = (tg_s2_q == tg_s3_q) && (tg_s3_q != tg_lvl_q);
    wire evt_cmd = evt && ev.is_cmd;
    wire evt_nib = evt && !ev.is_cmd;
    wire [7:0] cmd_byte = ev.data;
    wire [3:0] nibble = ev.data[3:0];

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // RULE_22 prefix priority chain
    wire is_all_pixel = cmd_byte[6:2] == lcd_cmd_pkg::PFX_ALL_PIXEL;
    wire is_blink = !is_all_pixel
        && (cmd_byte[6:3] == lcd_cmd_pkg::PFX_BLINK);
    wire is_ic_op = !is_all_pixel && !is_blink
        && (cmd_byte[6:3] == lcd_cmd_pkg::PFX_IC_OP);
    wire hi_taken = is_all_pixel || is_blink || is_ic_op;
    wire is_mode = !hi_taken && (cmd_byte[6:5] == lcd_cmd_pkg::PFX_MODE);
    wire is_display = !hi_taken
        && (cmd_byte[6:5] == lcd_cmd_pkg::PFX_DISPLAY);
    wire is_address = !hi_taken
        && (cmd_byte[6:5] == lcd_cmd_pkg::PFX_ADDRESS);

    wire do_all_pixel = evt_cmd && is_all_pixel;
    wire do_blink = evt_cmd && is_blink;
    wire do_ic_op = evt_cmd && is_ic_op;
    wire do_mode = evt_cmd && is_mode;
    wire do_display = evt_cmd && is_display;
    wire do_address = evt_cmd && is_address;
    // RULE_09 software reset strobe
    wire soft_rst = do_ic_op && cmd_byte[lcd_cmd_pkg::BIT_SOFT_RST];

    // ----------------------------------------
    // Settings
    // ----------------------------------------
    logic display_on_setting_q;
    logic bias_half_q;
    logic [1:0] frame_rate_q;
    logic frame_inv_q;
    logic [1:0] drive_mode_q;
    logic addr_msb_q;
    logic ext_clk_q;
    logic [1:0] blink_q;
    logic all_on_q;
    logic all_off_q;
    logic [5:0] addr_q;
    logic [5:0] addr_d;
    logic display_enable_q;

    // RULE_04 mode set
    // RULE_19 software reset blanks
    always_ff @(posedge CORE_CLK) begin
        if (RESET || soft_rst) begin
            display_on_setting_q <= lcd_cmd_pkg::RST_DISP_ON;
        end else if (do_mode) begin
            display_on_setting_q <= cmd_byte[lcd_cmd_pkg::BIT_DISP_ON];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            bias_half_q <= lcd_cmd_pkg::RST_BIAS;
        end else if (do_mode) begin
            bias_half_q <= cmd_byte[lcd_cmd_pkg::BIT_BIAS];
        end
    end

    // RULE_06 frame rate and inversion
    // RULE_07 drive mode
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            frame_rate_q <= lcd_cmd_pkg::RST_FRAME;
            frame_inv_q <= lcd_cmd_pkg::RST_INVERT;
            drive_mode_q <= lcd_cmd_pkg::RST_DRIVE;
        end else if (do_display) begin
            frame_rate_q <= cmd_byte[lcd_cmd_pkg::FR_HI:lcd_cmd_pkg::FR_LO];
            frame_inv_q <= cmd_byte[lcd_cmd_pkg::BIT_INVERT];
            drive_mode_q <=
                cmd_byte[lcd_cmd_pkg::DRV_HI:lcd_cmd_pkg::DRV_LO];
        end
    end

    // RULE_08 address MSB store
    always_ff @(posedge CORE_CLK) begin
        if (RESET || soft_rst) begin
            addr_msb_q <= lcd_cmd_pkg::RST_ADDR_MSB;
        end else if (do_ic_op) begin
            addr_msb_q <= cmd_byte[lcd_cmd_pkg::BIT_ADDR_MSB];
        end
    end

    // RULE_10 display clock source
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ext_clk_q <= lcd_cmd_pkg::RST_EXT_CLK;
        end else if (do_ic_op) begin
            ext_clk_q <= cmd_byte[lcd_cmd_pkg::BIT_EXT_CLK];
        end
    end

    // RULE_11 blink rate
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            blink_q <= lcd_cmd_pkg::RST_BLINK;
        end else if (do_blink) begin
            blink_q <= cmd_byte[lcd_cmd_pkg::BLK_HI:lcd_cmd_pkg::BLK_LO];
        end
    end

    // RULE_12 all pixel forcing
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            all_on_q <= lcd_cmd_pkg::RST_ALL_ON;
            all_off_q <= lcd_cmd_pkg::RST_ALL_OFF;
        end else if (do_all_pixel) begin
            all_on_q <= cmd_byte[lcd_cmd_pkg::BIT_ALL_ON];
            all_off_q <= cmd_byte[lcd_cmd_pkg::BIT_ALL_OFF];
        end
    end

    // RULE_13 inhibit blanks output
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            display_enable_q <= 1'b0;
        end else begin
            display_enable_q <= display_on_setting_q && inh_q;
        end
    end

    // ----------------------------------------
    // Display RAM address
    // ----------------------------------------
    // RULE_05 address load
    // RULE_15 step per nibble
    // RULE_17 wrap after last
    assign addr_d = soft_rst ? lcd_cmd_pkg::FIRST_ADDR
        : do_address ? {addr_msb_q, cmd_byte[lcd_cmd_pkg::ADDR_LO_HI:0]}
        : evt_nib ? lcd_cmd_pkg::next_addr(addr_q)
        : addr_q;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            addr_q <= lcd_cmd_pkg::FIRST_ADDR;
        end else begin
            addr_q <= addr_d;
        end
    end

    // ----------------------------------------
    // Display RAM
    // ----------------------------------------
    // RULE_14 35 by 4 storage
    // RULE_21 nibble bit 0 is common 0
    wire ram_wr_en = evt_nib;

    display_ram_mem #(
        .DEPTH(lcd_cmd_pkg::RAM_DEPTH),
        .AW(lcd_cmd_pkg::ADDR_W),
        .DW(lcd_cmd_pkg::NIB_W)
    ) u_ram (
        .clk(CORE_CLK),
        .wr_en(ram_wr_en),
        .wr_addr(addr_q),
        .wr_data(nibble),
        .rd_addr(RAM_READ_ADDR),
        .rd_data(RAM_READ_DATA)
    );

    assign WRITE_ADDR = addr_q;
    assign DISPLAY_ENABLE = display_enable_q;
    assign BIAS_HALF = bias_half_q;
    assign FRAME_RATE = frame_rate_q;
    assign FRAME_INVERSION = frame_inv_q;
    assign DRIVE_MODE = drive_mode_q;
    assign EXT_CLOCK_SELECT = ext_clk_q;
    assign BLINK_RATE = blink_q;
    assign ALL_PIXELS_ON = all_on_q;
    assign ALL_PIXELS_OFF = all_off_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    a_addr_wrap: assert property ( // RULE_17
        evt_nib && addr_q == lcd_cmd_pkg::LAST_ADDR
        |=> addr_q == lcd_cmd_pkg::FIRST_ADDR)
        else $error("address did not wrap to zero");

    a_addr_step: assert property ( // RULE_15
        evt_nib && addr_q != lcd_cmd_pkg::LAST_ADDR
        |=> addr_q == 6'($past(addr_q) + 6'h01))
        else $error("address did not step after nibble");

    a_addr_load: assert property ( // RULE_05
        do_address |=> addr_q == {$past(addr_msb_q), $past(cmd_byte[4:0])})
        else $error("address set not loaded");

    a_mode_fields: assert property ( // RULE_04
        do_mode |=> display_on_setting_q == $past(cmd_byte[3])
        && bias_half_q == $past(cmd_byte[2]))
        else $error("mode set fields wrong");

    a_display_ctl: assert property ( // RULE_06
        do_display |=> FRAME_RATE == $past(cmd_byte[4:3])
        && FRAME_INVERSION == $past(cmd_byte[2])
        && DRIVE_MODE == $past(cmd_byte[1:0]))
        else $error("display control fields wrong");

    a_ic_op_store: assert property ( // RULE_08
        do_ic_op && !soft_rst |=> addr_msb_q == $past(cmd_byte[2])
        && EXT_CLOCK_SELECT == $past(cmd_byte[0]))
        else $error("ic operation fields wrong");

    a_soft_reset: assert property ( // RULE_19
        soft_rst |=> !display_on_setting_q
        && addr_q == lcd_cmd_pkg::FIRST_ADDR ##1 !DISPLAY_ENABLE)
        else $error("software reset incomplete");

    a_blink_rate: assert property ( // RULE_11
        do_blink |=> BLINK_RATE == $past(cmd_byte[1:0]))
        else $error("blink rate not loaded");

    a_all_pixel: assert property ( // RULE_12
        do_all_pixel |=> ALL_PIXELS_ON == $past(cmd_byte[1])
        && ALL_PIXELS_OFF == $past(cmd_byte[0]))
        else $error("all pixel fields wrong");

    a_inhibit_off: assert property ( // RULE_13
        !inh_q |=> !DISPLAY_ENABLE)
        else $error("display shown while inhibited");

    a_no_stray_write: assert property ( // RULE_18
        ram_wr_en |-> $changed(tg_s3_q) && !ev.is_cmd)
        else $error("ram written without a nibble");

    a_cmd_exclusive: assert property ( // RULE_22
        evt_cmd |-> $onehot0({is_all_pixel, is_blink, is_ic_op,
                              is_mode, is_display, is_address})
        && (cmd_byte[6:5] != lcd_cmd_pkg::PFX_ADDRESS || do_address))
        else $error("command decode not exclusive");
endmodule // lcd_segment_serial_command_decoder

// *** serial_event_if.sv ***
interface serial_event_if;
    logic toggle;
    logic is_cmd;
    logic [7:0] data;

    modport link (output toggle, output is_cmd, output data);
    modport core (input toggle, input is_cmd, input data);
endinterface

// *** serial_link_rx.sv ***
module serial_link_rx (
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    input wire logic link_reset,
    serial_event_if.link ev
);
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic data_mode_q;
    logic toggle_q;
    logic is_cmd_q;
    logic [7:0] data_q;

    wire byte_done = bit_cnt_q == lcd_cmd_pkg::CNT_BYTE;
    wire nib_done = (bit_cnt_q == lcd_cmd_pkg::CNT_NIBBLE) || byte_done;
    wire emit = data_mode_q ? nib_done : byte_done;

    // ----------------------------------------
    // Bit capture on rising edge
    // ----------------------------------------
    // RULE_01 counter held while deselected
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_q <= lcd_cmd_pkg::CNT_IDLE;
        end else begin
            bit_cnt_q <= byte_done ? lcd_cmd_pkg::CNT_FIRST
                                   : 4'(bit_cnt_q + 4'h1);
        end
    end

    // RULE_02 MSB first shift
    always_ff @(posedge serial_clock) begin
        shift_q <= {shift_q[6:0], serial_data_in};
    end

    // ----------------------------------------
    // Byte and nibble hand-off on falling edge
    // ----------------------------------------
    // RULE_03 flag picks data mode
    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            data_mode_q <= 1'b0;
        end else if (byte_done && !data_mode_q) begin
            data_mode_q <= !shift_q[lcd_cmd_pkg::BIT_CFLAG];
        end
    end

    // RULE_18 only whole nibbles leave
    // RULE_16 data stream continues
    always_ff @(negedge serial_clock or posedge link_reset) begin
        if (link_reset) begin
            toggle_q <= 1'b0;
            is_cmd_q <= 1'b0;
            data_q <= 8'h00;
        end else if (emit) begin
            toggle_q <= !toggle_q;
            is_cmd_q <= !data_mode_q;
            data_q <= shift_q;
        end
    end

    assign ev.toggle = toggle_q;
    assign ev.is_cmd = is_cmd_q;
    assign ev.data = data_q;
endmodule // serial_link_rx

// *** tb_lcd_segment_serial_command_decoder.sv ***
module tb_lcd_segment_serial_command_decoder;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic reset = 1'b0;
    logic inhibit_n = 1'b1;
    logic [5:0] rd_addr = 6'h00;
    logic sclk, csn, sd;
    logic [3:0] rd_data;
    logic [5:0] wr_addr;
    logic disp_en, bias_half, frame_inv, ext_clk, all_on, all_off;
    logic [1:0] frame_rate, drive_mode, blink_rate;
    logic [11:0] cfg;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    assign cfg = {disp_en, bias_half, frame_rate, frame_inv, drive_mode,
                  ext_clk, blink_rate, all_on, all_off};

    always #25 core_clk = ~core_clk;

    lcd_host_model host_u (.sclk(sclk), .csn(csn), .sd(sd));

    lcd_segment_serial_command_decoder dut_u (
        .CORE_CLK(core_clk),
        .RESET(reset),
        .SERIAL_CLOCK(sclk),
        .CHIP_SELECT_N(csn),
        .SERIAL_DATA_IN(sd),
        .DISPLAY_INHIBIT_N(inhibit_n),
        .RAM_READ_ADDR(rd_addr),
        .RAM_READ_DATA(rd_data),
        .WRITE_ADDR(wr_addr),
        .DISPLAY_ENABLE(disp_en),
        .BIAS_HALF(bias_half),
        .FRAME_RATE(frame_rate),
        .FRAME_INVERSION(frame_inv),
        .DRIVE_MODE(drive_mode),
        .EXT_CLOCK_SELECT(ext_clk),
        .BLINK_RATE(blink_rate),
        .ALL_PIXELS_ON(all_on),
        .ALL_PIXELS_OFF(all_off)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic cmd(input logic [7:0] b);
        host_u.begin_frame();
        host_u.put_bits(b, 8);
        host_u.end_frame();
        settle();
    endtask

    task automatic rd(input logic [5:0] a, input logic [3:0] exp);
        @(posedge core_clk) rd_addr <= a;
        @(posedge core_clk);
        #1;
        check("ram", 12'(rd_data), 12'(exp));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("config", cfg, 12'h040);
        check("wr_addr", 12'(wr_addr), 12'h000);
        $display("test reset done");
    endtask

    task automatic t_cs_high();
        host_u.put_bits(8'h5a, 3);
        cmd(8'hf1);
        check("blink", 12'(blink_rate), 12'h001);
        $display("test deselected clocks done");
    endtask

    task automatic t_mode();
        cmd(8'hdc);
        check("enable", 12'(disp_en), 12'h001);
        check("bias", 12'(bias_half), 12'h001);
        @(posedge core_clk) inhibit_n <= 1'b0;
        settle();
        check("inhibit", 12'(disp_en), 12'h000);
        @(posedge core_clk) inhibit_n <= 1'b1;
        settle();
        check("enable", 12'(disp_en), 12'h001);
        cmd(8'hd3);
        check("mode", 12'({disp_en, bias_half}), 12'h000);
        $display("test mode set done");
    endtask

    task automatic t_disp_ctl();
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            cmd({3'b101, k, k[0], ~k});
            check("rate", 12'(frame_rate), 12'(k));
            check("invert", 12'(frame_inv), 12'(k[0]));
            check("drive", 12'(drive_mode), 12'(2'(~k)));
        end
        $display("test display control done");
    endtask

    task automatic t_blink_pix();
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            cmd({5'b11110, 1'b1, k});
            check("blink", 12'(blink_rate), 12'(k));
            cmd({6'b111111, k});
            check("pixel", 12'({all_on, all_off}), 12'(k));
        end
        cmd(8'he2);
        check("config", cfg, 12'h38f);
        $display("test blink and pixel done");
    endtask

    task automatic t_ram();
        host_u.begin_frame();
        host_u.put_bits(8'hec, 8);
        host_u.put_bits(8'h01, 8);
        host_u.put_bits(8'ha5, 8);
        host_u.put_bits(8'h3c, 8);
        host_u.end_frame();
        settle();
        check("wr_addr", 12'(wr_addr), 12'h002);
        rd(6'h21, 4'ha);
        rd(6'h22, 4'h5);
        rd(6'h00, 4'h3);
        rd(6'h01, 4'hc);
        host_u.begin_frame();
        host_u.put_bits(8'he8, 8);
        host_u.put_bits(8'h00, 8);
        host_u.put_bits(8'h06, 6);
        host_u.end_frame();
        settle();
        check("wr_addr", 12'(wr_addr), 12'h001);
        rd(6'h00, 4'h1);
        rd(6'h01, 4'hc);
        $display("test display ram done");
    endtask

    task automatic t_soft_reset();
        cmd(8'hc8);
        host_u.begin_frame();
        host_u.put_bits(8'hed, 8);
        host_u.put_bits(8'h82, 8);
        host_u.end_frame();
        settle();
        check("enable", 12'(disp_en), 12'h001);
        check("ext_clk", 12'(ext_clk), 12'h001);
        check("wr_addr", 12'(wr_addr), 12'h022);
        host_u.recover(8'hea);
        settle();
        check("config", cfg, 12'h38f);
        check("wr_addr", 12'(wr_addr), 12'h000);
        rd(6'h21, 4'ha);
        cmd(8'h85);
        check("wr_addr", 12'(wr_addr), 12'h005);
        $display("test software reset done");
    endtask

    initial begin
        // Rising edge at time zero for the asynchronously reset link flops
        reset <= 1'b1;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        t_reset();
        t_cs_high();
        t_mode();
        t_disp_ctl();
        t_blink_pix();
        t_ram();
        t_soft_reset();
        stop_test();
    end
endmodule // tb_lcd_segment_serial_command_decoder
